// ### hdl/hasd_regs.vh
// Constants for the host-side address/data slice
`ifndef HASD_REGS_VH
`define HASD_REGS_VH
// Host group command codes (block-local encoding)
`define HASD_CMD_W 5
`define HASD_CMD_NOP 5'h00
`define HASD_CMD_LATCH_ADDR 5'h01
`define HASD_CMD_SNOOP_DRIVE 5'h02
`define HASD_CMD_CFG_RD 5'h03
`define HASD_CMD_CFG_WR_LO 5'h04
`define HASD_CMD_CFG_WR_HI 5'h05
`define HASD_CMD_WR_DATA 5'h06
`define HASD_CMD_RD_DATA 5'h07
`define HASD_CMD_RD_STOP 5'h08
`define HASD_CMD_HOLD 5'h09
// Widths and reset values
`define HASD_LANE_W 16
`define HASD_FIFO_DEPTH 16
`define HASD_MODE_NORMAL 1'b0
`define HASD_MODE_CLKLOOP 1'b1
`define HASD_STRAP_BIT 11
`endif

// ### hdl/hasd_fifo.v
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module hasd_fifo #(
    parameter WIDTH = 36,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clock,
    input wire rst_n,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output reg [WIDTH-1:0] out_data,
    output reg out_valid,
    input wire out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop_mem;
    wire load_out;
    wire [AW:0] occupancy;

    // ----------------------------------------
    // Storage and output stage
    // ----------------------------------------
    // The output register counts as a slot, so the FIFO holds DEPTH words in all
    assign occupancy = count + {{AW{1'b0}}, out_valid};
    assign in_ready = (occupancy < DEPTH[AW:0]);
    assign push = in_valid && in_ready;
    assign load_out = (!out_valid || out_ready) && (count != {(AW+1){1'b0}});
    assign pop_mem = load_out;

    always @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
            out_data <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop_mem) begin
                rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
                out_data <= mem[rd_ptr];
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
            if (push && !pop_mem) begin
                count <= count + {{AW{1'b0}}, 1'b1};
            end else if (!push && pop_mem) begin
                count <= count - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule

// ### hdl/hasd_slice.v
// Host-bus side of one address/data slice of the host bridge
`timescale 1ns/1ps
`include "hasd_regs.vh"
module hasd_slice #(
    parameter LANE_W = `HASD_LANE_W,
    parameter FIFO_DEPTH = `HASD_FIFO_DEPTH
) (
    input wire clock,
    input wire rst_n,
    // Strap pin shared with the end-of-line function
    input wire end_of_line_strap_pin_in,
    output reg end_of_line_strap_pin_out,
    output reg end_of_line_strap_pin_oe,
    input wire end_of_line_warning,
    input wire pll_host_clock,
    // Host command group from the bridge controller
    input wire [`HASD_CMD_W-1:0] host_group_command,
    // Host address lines for this slice
    input wire [LANE_W-1:0] host_addr_in,
    output reg [LANE_W-1:0] host_addr_out,
    output reg host_addr_oe,
    // Host data: two lanes of this slice
    input wire [2*LANE_W-1:0] host_data_in,
    output reg [2*LANE_W-1:0] host_data_out,
    output reg host_data_oe,
    input wire [3:0] host_byte_parity_in,
    output reg [3:0] host_byte_parity_out,
    output reg host_byte_parity_oe,
    // Captured PCI master address half for inquire cycles
    input wire [LANE_W-1:0] snoop_address,
    // Write stream to the memory/PCI side
    output wire [2*LANE_W+3:0] wr_data,
    output wire wr_valid,
    input wire wr_ready,
    output wire wr_parity_error,
    // Read data from the memory/PCI side
    input wire [2*LANE_W-1:0] rd_data,
    input wire rd_valid,
    output wire rd_ready,
    // Strap results and the latched address
    output reg high_order_slice,
    output reg clock_loop_mode,
    output reg [2*LANE_W-1:0] address_latch
);
    localparam ST_IDLE = 2'h0;
    localparam ST_SNOOP = 2'h1;
    localparam ST_CFG_RD = 2'h2;
    localparam ST_RD = 2'h3;

    reg eol_meta;
    reg eol_sync;
    reg a11_meta;
    reg a11_sync;
    reg strap_done;
    reg [1:0] state;
    reg [1:0] next_state;
    reg [LANE_W-1:0] addr_meta;
    reg [LANE_W-1:0] addr_sync;
    reg [2*LANE_W-1:0] data_meta;
    reg [2*LANE_W-1:0] data_sync;
    reg [3:0] par_meta;
    reg [3:0] par_sync;
    reg cfg_wr_pending;
    reg cfg_wr_hi;
    reg wr_push;
    reg rd_pull;
    wire [2*LANE_W+3:0] fifo_out;
    wire fifo_ready;
    wire cfg_wr_now;
    wire cfg_wr_drive;
    wire cfg_wr_use_hi;

    // ----------------------------------------
    // Parity helper
    // ----------------------------------------
    // byte n parity
    function [3:0] byte_parity;
        input [31:0] d;
        integer i;
        begin
            byte_parity = 4'h0;
            for (i = 0; i < 4; i = i + 1) begin
                byte_parity[i] = ^d[8*i +: 8];
            end
        end
    endfunction

    // ----------------------------------------
    // Pin input synchronisers
    // ----------------------------------------
    // Strap pins keep running through reset so their level is ready at release
    always @(posedge clock) begin
        eol_meta <= end_of_line_strap_pin_in;
        eol_sync <= eol_meta;
        a11_meta <= host_addr_in[`HASD_STRAP_BIT];
        a11_sync <= a11_meta;
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            addr_meta <= {LANE_W{1'b0}};
            addr_sync <= {LANE_W{1'b0}};
            data_meta <= {(2*LANE_W){1'b0}};
            data_sync <= {(2*LANE_W){1'b0}};
            par_meta <= 4'h0;
            par_sync <= 4'h0;
        end else begin
            addr_meta <= host_addr_in;
            addr_sync <= addr_meta;
            data_meta <= host_data_in;
            data_sync <= data_meta;
            par_meta <= host_byte_parity_in;
            par_sync <= par_meta;
        end
    end

    // ----------------------------------------
    // Straps caught after reset release
    // ----------------------------------------
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            strap_done <= 1'b0;
            high_order_slice <= 1'b0;
            clock_loop_mode <= `HASD_MODE_NORMAL;
        end else if (!strap_done) begin
            strap_done <= 1'b1;
            high_order_slice <= eol_sync;
            clock_loop_mode <= eol_sync ? a11_sync : `HASD_MODE_NORMAL;
        end
    end

    always @* begin
        end_of_line_strap_pin_oe = strap_done;
        end_of_line_strap_pin_out = clock_loop_mode ? pll_host_clock : end_of_line_warning;
    end

    // ----------------------------------------
    // Command sequencing
    // ----------------------------------------
    // commands sampled on rising edge
    always @* begin
        next_state = state;
        case (host_group_command)
            `HASD_CMD_SNOOP_DRIVE: next_state = ST_SNOOP;
            `HASD_CMD_CFG_RD: next_state = ST_CFG_RD;
            `HASD_CMD_RD_DATA: next_state = ST_RD;
            `HASD_CMD_HOLD: next_state = state;
            default: next_state = ST_IDLE;
        endcase
        if (!strap_done) begin
            next_state = ST_IDLE;
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            address_latch <= {(2*LANE_W){1'b0}};
            cfg_wr_pending <= 1'b0;
            cfg_wr_hi <= 1'b0;
            wr_push <= 1'b0;
            rd_pull <= 1'b0;
        end else begin
            state <= next_state;
            wr_push <= 1'b0;
            rd_pull <= 1'b0;
            if (host_group_command == `HASD_CMD_LATCH_ADDR) begin
                address_latch <= {{LANE_W{1'b0}}, addr_sync};
            end
            if (host_group_command == `HASD_CMD_CFG_WR_LO || host_group_command == `HASD_CMD_CFG_WR_HI) begin
                cfg_wr_pending <= 1'b1;
                cfg_wr_hi <= (host_group_command == `HASD_CMD_CFG_WR_HI);
            end else if (host_group_command != `HASD_CMD_HOLD) begin
                cfg_wr_pending <= 1'b0;
            end
            if (host_group_command == `HASD_CMD_WR_DATA) begin
                wr_push <= 1'b1;
            end
            if (next_state == ST_RD) begin
                rd_pull <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Host write data path into the FIFO
    // ----------------------------------------
    // parity taken as input on writes
    hasd_fifo #(
        .WIDTH(2*LANE_W+4),
        .DEPTH(FIFO_DEPTH),
        .AW(4)
    ) u_wr_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .in_data({par_sync, data_sync}),
        .in_valid(wr_push),
        .in_ready(fifo_ready),
        .out_data(fifo_out),
        .out_valid(wr_valid),
        .out_ready(wr_ready)
    );
    assign wr_data = fifo_out;
    assign wr_parity_error = wr_valid && (byte_parity(fifo_out[31:0]) != fifo_out[35:32]);
    assign rd_ready = rd_pull;
    // Config write answers at the command edge, as the other commands do
    assign cfg_wr_now = (host_group_command == `HASD_CMD_CFG_WR_LO) ||
        (host_group_command == `HASD_CMD_CFG_WR_HI);
    assign cfg_wr_drive = cfg_wr_now || (cfg_wr_pending && host_group_command == `HASD_CMD_HOLD);
    assign cfg_wr_use_hi = cfg_wr_now ? (host_group_command == `HASD_CMD_CFG_WR_HI) : cfg_wr_hi;

    // ----------------------------------------
    // Host bus drivers
    // ----------------------------------------
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            host_addr_out <= {LANE_W{1'b0}};
            host_addr_oe <= 1'b0;
            host_data_out <= {(2*LANE_W){1'b0}};
            host_data_oe <= 1'b0;
            host_byte_parity_out <= 4'h0;
            host_byte_parity_oe <= 1'b0;
        end else begin
            host_addr_oe <= 1'b0;
            host_data_oe <= 1'b0;
            host_byte_parity_oe <= 1'b0;
            case (next_state)
                ST_SNOOP: begin
                    host_addr_out <= snoop_address;
                    host_addr_oe <= 1'b1;
                end
                ST_CFG_RD: begin
                    host_data_out <= {addr_sync, addr_sync};
                    host_byte_parity_out <= byte_parity({addr_sync, addr_sync});
                    host_data_oe <= 1'b1;
                    host_byte_parity_oe <= 1'b1;
                end
                ST_RD: begin
                    if (rd_valid) begin
                        host_data_out <= rd_data;
                        host_byte_parity_out <= byte_parity(rd_data);
                    end
                    host_data_oe <= 1'b1;
                    host_byte_parity_oe <= 1'b1;
                end
                default: begin
                    host_addr_oe <= 1'b0;
                end
            endcase
            if (cfg_wr_drive) begin
                host_addr_out <= cfg_wr_use_hi ? data_sync[2*LANE_W-1:LANE_W] : data_sync[LANE_W-1:0];
                host_addr_oe <= 1'b1;
            end
        end
    end
endmodule

// ### tb/hasd_slice_sva.sv
// Bus-side checks for the host address/data slice
`timescale 1ns/1ps
`include "hasd_regs.vh"
module hasd_slice_sva (
    input wire clock,
    input wire rst_n,
    input wire [4:0] host_group_command,
    input wire [15:0] snoop_address,
    input wire [15:0] host_addr_out,
    input wire host_addr_oe,
    input wire [31:0] host_data_out,
    input wire host_data_oe,
    input wire [3:0] host_byte_parity_out,
    input wire host_byte_parity_oe,
    input wire end_of_line_strap_pin_out,
    input wire end_of_line_warning,
    input wire pll_host_clock,
    input wire high_order_slice,
    input wire clock_loop_mode
);
    reg [4:0] pc;
    wire [31:0] d = host_data_out;
    wire [3:0] p = host_byte_parity_out;
    wire [3:0] odd = {^{p[3], d[31:24]}, ^{p[2], d[23:16]}, ^{p[1], d[15:8]}, ^{p[0], d[7:0]}};
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Command taken at the previous edge
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            pc <= 5'h00;
        else
            pc <= host_group_command;
    end
    chk_snoop_addr: assert property (pc == `HASD_CMD_SNOOP_DRIVE |->
        host_addr_oe && host_addr_out == $past(snoop_address)) else $error("snoop address wrong");
    chk_cfg_copy: assert property (pc == `HASD_CMD_CFG_RD |->
        host_data_oe && d[31:16] == d[15:0]) else $error("config read copy wrong");
    chk_parity_even: assert property (host_byte_parity_oe |-> odd == 4'h0)
        else $error("host parity not even");
    chk_parity_timing: assert property (host_byte_parity_oe |-> host_data_oe)
        else $error("parity driven without data");
    chk_bus_release: assert property (pc == `HASD_CMD_NOP |->
        !host_addr_oe && !host_data_oe && !host_byte_parity_oe) else $error("bus not released");
    chk_addr_input_only: assert property ($rose(host_addr_oe) |-> pc inside {5'h02, 5'h04, 5'h05})
        else $error("address driven in processor cycle");
    chk_clock_loop: assert property (end_of_line_strap_pin_out ==
        (clock_loop_mode ? pll_host_clock : end_of_line_warning)) else $error("strap pin output wrong");
    chk_test_strap: assert property (clock_loop_mode |-> high_order_slice)
        else $error("test mode on low slice");
endmodule
bind hasd_slice hasd_slice_sva chk (.clock, .rst_n, .host_group_command, .snoop_address,
    .host_addr_out, .host_addr_oe, .host_data_out, .host_data_oe, .host_byte_parity_out,
    .host_byte_parity_oe, .end_of_line_strap_pin_out, .end_of_line_warning, .pll_host_clock,
    .high_order_slice, .clock_loop_mode);

// ### tb/hasd_far_model.sv
// Memory-side stream partner: write sink and read source
`timescale 1ns/1ps
module hasd_far_model (
    input wire clock,
    input wire rst_n,
    input wire stall,
    input wire [35:0] wr_data,
    input wire wr_valid,
    output wire wr_ready,
    input wire [31:0] rd_word,
    input wire rd_go,
    output wire [31:0] rd_data,
    output reg rd_valid,
    input wire rd_ready
);
    reg [35:0] got [$];
    assign wr_ready = !stall;
    // Idle read lines show the inverse word
    assign rd_data = rd_valid ? rd_word : ~rd_word;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid <= 1'b0;
        end else begin
            if (wr_valid && wr_ready)
                got.push_back(wr_data);
            rd_valid <= rd_valid ? !rd_ready : rd_go;
        end
    end
endmodule

// ### tb/hasd_slice_test.sv
// Self-checking bench for the host address/data slice
`timescale 1ns/1ps
`include "hasd_regs.vh"
`define CHK(n, e, g) begin checked++; if ((e) !== (g)) begin fail_count++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module hasd_slice_test;
    reg clock = 0, rst_n = 0, eol_drv = 0, end_of_line_warning = 0, pll_host_clock = 0, stall = 1, rd_go = 0;
    reg [4:0] host_group_command = 5'h00;
    reg [15:0] addr_drv = 16'h0000, snoop_address = 16'h0000;
    reg [31:0] data_drv = 32'h0, rd_word = 32'h0;
    reg [3:0] par_drv = 4'h0;
    reg data_en = 0;
    int fail_count = 0, checked = 0;
    wire end_of_line_strap_pin_in, end_of_line_strap_pin_out, end_of_line_strap_pin_oe, host_addr_oe;
    wire host_data_oe, host_byte_parity_oe, wr_valid, wr_ready, wr_parity_error, rd_valid, rd_ready;
    wire high_order_slice, clock_loop_mode;
    wire [15:0] host_addr_in, host_addr_out;
    wire [31:0] host_data_in, host_data_out, rd_data, address_latch;
    wire [3:0] host_byte_parity_in, host_byte_parity_out;
    wire [35:0] wr_data;
    // Shared lines; only the data and parity lines have pull-downs
    assign host_addr_in = host_addr_oe ? host_addr_out : addr_drv;
    assign host_data_in = host_data_oe ? host_data_out : (data_en ? data_drv : 32'h0);
    assign host_byte_parity_in = host_byte_parity_oe ? host_byte_parity_out : (data_en ? par_drv : 4'h0);
    assign end_of_line_strap_pin_in = end_of_line_strap_pin_oe ? end_of_line_strap_pin_out : eol_drv;
    always #12.5 clock = ~clock;
    always #7 pll_host_clock = ~pll_host_clock;
    hasd_slice uut (.clock, .rst_n, .end_of_line_strap_pin_in, .end_of_line_strap_pin_out,
        .end_of_line_strap_pin_oe, .end_of_line_warning, .pll_host_clock, .host_group_command,
        .host_addr_in, .host_addr_out, .host_addr_oe, .host_data_in, .host_data_out, .host_data_oe,
        .host_byte_parity_in, .host_byte_parity_out, .host_byte_parity_oe, .snoop_address, .wr_data,
        .wr_valid, .wr_ready, .wr_parity_error, .rd_data, .rd_valid, .rd_ready, .high_order_slice,
        .clock_loop_mode, .address_latch);
    hasd_far_model far (.clock, .rst_n, .stall, .wr_data, .wr_valid, .wr_ready, .rd_word, .rd_go,
        .rd_data, .rd_valid, .rd_ready);
    function [3:0] par(input [31:0] d);
        par = {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
    endfunction
    task cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    task cmd(input [4:0] c);
        host_group_command = c;
        @(negedge clock);
    endtask
    task t_reset(input e, input t);
        rst_n = 0;
        eol_drv = e;
        addr_drv = {4'h0, t, 11'h000};
        cyc(2);
        rst_n = 1;
        cyc(3);
        end_of_line_warning = 1;
        `CHK("high_order_slice", e, high_order_slice)
        `CHK("clock_loop_mode", e & t, clock_loop_mode)
        `CHK("eol_oe", 1'b1, end_of_line_strap_pin_oe)
        // Look at the strap pin just after each edge of the loop clock
        @(posedge pll_host_clock);
        #1;
        `CHK("eol_out_hi", 1'b1, end_of_line_strap_pin_out)
        @(negedge pll_host_clock);
        #1;
        `CHK("eol_out_lo", !(e & t), end_of_line_strap_pin_out)
        cyc(1);
    endtask
    task t_cfg;
        addr_drv = 16'h5a3c;
        data_drv = 32'h1234_abcd;
        data_en = 1;
        cyc(3);
        cmd(`HASD_CMD_CFG_RD);
        `CHK("cfg_rd", {2{16'h5a3c}}, host_data_out)
        cmd(`HASD_CMD_NOP);
        `CHK("data_oe", 1'b0, host_data_oe)
        // Let the slice's own read data leave the data synchronisers
        cyc(2);
        cmd(`HASD_CMD_CFG_WR_LO);
        `CHK("cfg_wr_lo", 16'habcd, host_addr_out)
        cmd(`HASD_CMD_CFG_WR_HI);
        `CHK("cfg_wr_hi", 16'h1234, host_addr_out)
        cmd(`HASD_CMD_HOLD);
        `CHK("cfg_wr_hold", 1'b1, host_addr_oe)
        cmd(`HASD_CMD_NOP);
        `CHK("cfg_wr_rel", 1'b0, host_addr_oe)
        data_en = 0;
    endtask
    task t_snoop;
        snoop_address = 16'hc0de;
        addr_drv = 16'h0ff0;
        cyc(3);
        cmd(`HASD_CMD_LATCH_ADDR);
        `CHK("latch", 16'h0ff0, address_latch[15:0])
        cmd(`HASD_CMD_SNOOP_DRIVE);
        `CHK("snoop", 16'hc0de, host_addr_out)
        cmd(`HASD_CMD_HOLD);
        `CHK("hold_oe", 1'b1, host_addr_oe)
        cmd(`HASD_CMD_NOP);
        `CHK("addr_oe", 1'b0, host_addr_oe)
    endtask
    task t_write;
        reg [31:0] d;
        data_en = 1;
        for (int i = 0; i < 17; i++) begin
            data_drv = 32'h0103_0507 * i;
            par_drv = par(data_drv) ^ {3'h0, i == 0};
            cyc(3);
            cmd(`HASD_CMD_WR_DATA);
            cmd(`HASD_CMD_NOP);
        end
        `CHK("full_valid", 1'b1, wr_valid)
        `CHK("par_err", 1'b1, wr_parity_error)
        stall = 0;
        cyc(40);
        `CHK("count", 16, far.got.size())
        for (int i = 0; i < 16 && i < far.got.size(); i++) begin
            d = 32'h0103_0507 * i;
            `CHK("wr_word", {par(d) ^ {3'h0, i == 0}, d}, far.got[i])
        end
        `CHK("empty", 1'b0, wr_valid)
        data_en = 0;
    endtask
    task t_read;
        rd_word = 32'h8e71_0c3f;
        host_group_command = `HASD_CMD_RD_DATA;
        rd_go = 1;
        cyc(1);
        rd_go = 0;
        for (int k = 0; k < 10 && !(host_data_oe === 1'b1 && host_data_out === rd_word); k++)
            cyc(1);
        `CHK("rd_data", rd_word, host_data_out)
        `CHK("rd_par", par(rd_word), host_byte_parity_out)
        `CHK("rd_par_oe", 1'b1, host_byte_parity_oe)
        cmd(`HASD_CMD_NOP);
        `CHK("par_oe", 1'b0, host_byte_parity_oe)
    endtask
    task finish_test;
        if (fail_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #(25 * 5000);
        fail_count++;
        finish_test;
    end
    initial begin
        t_reset(1'b1, 1'b0);
        t_cfg;
        t_snoop;
        t_write;
        t_read;
        t_reset(1'b0, 1'b1);
        t_cfg;
        t_reset(1'b1, 1'b1);
        cyc(5);
        finish_test;
    end
endmodule
